/* File: core/pgc_bert.sv */
// bit error rate pattern generator and checker with apb register slave
// assumes one pclk domain; external clock and reference arrive as sampled levels
`timescale 1ns/1ps
`include "pgc_defines.svh"
module pgc_bert #(
    parameter int CUST_WORDS = 4,
    parameter int FIFO_DEPTH = 16,
    parameter int DLY_MAX    = 16
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // clock sources
    input  wire logic        ext_bit_clk,
    input  wire logic        ext_ref_clk,
    // transmit link
    output logic             tx_data,
    output logic             tx_strobe,
    // receive link
    input  wire logic        rx_data,
    input  wire logic        ref_data
);
    localparam int CIW = $clog2(CUST_WORDS * 32);
    localparam int CWW = (CUST_WORDS > 1) ? $clog2(CUST_WORDS) : 1;
    localparam int DW  = $clog2(DLY_MAX);

    // lfsr helpers
    function automatic logic [4:0] seq_n(input pgc_pkg::pgc_len_e l);
        case (l)
            pgc_pkg::seq_len_seven:       seq_n = 5'd7;
            pgc_pkg::seq_len_fifteen:     seq_n = 5'd15;
            pgc_pkg::seq_len_seventeen:   seq_n = 5'd17;
            pgc_pkg::seq_len_twenty:      seq_n = 5'd20;
            pgc_pkg::seq_len_twentythree: seq_n = 5'd23;
            default:                      seq_n = 5'd4;
        endcase
    endfunction

    function automatic logic seq_fb(input logic [22:0] s, input pgc_pkg::pgc_len_e l);
        case (l)
            pgc_pkg::seq_len_seven:       seq_fb = s[5] ^ s[6];
            pgc_pkg::seq_len_fifteen:     seq_fb = s[13] ^ s[14];
            pgc_pkg::seq_len_seventeen:   seq_fb = s[13] ^ s[16];
            pgc_pkg::seq_len_twenty:      seq_fb = s[16] ^ s[19];
            pgc_pkg::seq_len_twentythree: seq_fb = s[17] ^ s[22];
            default:                      seq_fb = s[2] ^ s[3];
        endcase
    endfunction

    function automatic logic [22:0] seq_mask(input pgc_pkg::pgc_len_e l);
        seq_mask = 23'h7fffff >> (5'd23 - seq_n(l));
    endfunction

    // stage 1 is bit 0; feedback enters stage 1, stages move up by one
    function automatic logic [22:0] seq_shift(input logic [22:0] s, input pgc_pkg::pgc_len_e l,
                                              input logic in_bit);
        logic [22:0] n;
        n = {s[21:0], in_bit} & seq_mask(l);
        seq_shift = (n == '0) ? `PGC_SEED : n;
    endfunction

    // registers
    pgc_pkg::pgc_ctrl_s ctrl_reg;
    logic [15:0]        dens_reg;
    logic [15:0]        div_reg;
    logic [DW-1:0]      delay_reg;
    logic [31:0]        err_reg;
    logic [31:0]        bits_reg;
    logic [31:0]        prdata_reg;
    logic               pslverr_reg;
    logic [31:0]        cust_reg [CUST_WORDS];
    logic [CWW-1:0]     cust_wr_reg;

    // apb decode
    wire setup    = psel && !penable;
    wire access   = psel && penable;
    wire a_ctrl   = (paddr == `PGC_OFF_CTRL);
    wire a_dens   = (paddr == `PGC_OFF_DENS);
    wire a_cust   = (paddr == `PGC_OFF_CUST);
    wire a_div    = (paddr == `PGC_OFF_DIV);
    wire a_errs   = (paddr == `PGC_OFF_ERRS);
    wire a_bits   = (paddr == `PGC_OFF_BITS);
    wire a_stat   = (paddr == `PGC_OFF_STAT);
    wire a_clr    = (paddr == `PGC_OFF_CLR);
    wire a_delay  = (paddr == `PGC_OFF_DELAY);
    wire a_hit    = a_ctrl | a_dens | a_cust | a_div | a_errs | a_bits | a_stat | a_clr | a_delay;
    wire fifo_in_ready;
    wire wr_done  = access && pwrite && pready;
    wire cust_push = access && pwrite && a_cust;
    wire cnt_clr  = wr_done && a_clr;

    assign pready  = !(access && pwrite && a_cust) || fifo_in_ready;
    assign prdata  = prdata_reg;
    assign pslverr = access && pslverr_reg;

    // custom pattern load path
    wire        fifo_out_valid;
    wire [31:0] fifo_out_data;
    wire        tx_cust_busy = ctrl_reg.tx_en && (ctrl_reg.tx_mode == pgc_pkg::tx_custom);
    wire        fifo_pop = fifo_out_valid && !tx_cust_busy;

    pgc_fifo #(
        .W(32),
        .D(FIFO_DEPTH)
    ) u_cust_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (cust_push),
        .in_ready  (fifo_in_ready),
        .in_data   (pwdata),
        .out_valid (fifo_out_valid),
        .out_ready (!tx_cust_busy),
        .out_data  (fifo_out_data)
    );

    // clock source selection
    logic [2:0]  ext_clk_sync;
    logic [2:0]  ext_ref_sync;
    logic [15:0] div_cnt_reg;
    logic [7:0]  ref_gap_reg;
    logic [DLY_MAX-1:0] tick_hist;
    wire ext_clk_rise = ext_clk_sync[1] && !ext_clk_sync[2];
    wire ext_ref_rise = ext_ref_sync[1] && !ext_ref_sync[2];
    wire ref_lost     = (ref_gap_reg >= 8'(`PGC_REF_LOST_CYC));
    wire div_step     = ctrl_reg.ref_clk_sel ? ext_ref_rise : 1'b1;
    wire div_wrap     = div_step && (div_cnt_reg >= div_reg);
    wire bit_tick     = ctrl_reg.ext_clk_sel ? ext_clk_rise : div_wrap;
    wire samp_tick    = (delay_reg == '0) ? bit_tick : tick_hist[delay_reg - 1'b1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_clk_sync <= 3'h0;
            ext_ref_sync <= 3'h0;
            div_cnt_reg  <= 16'h0000;
            ref_gap_reg  <= 8'h00;
            tick_hist    <= '0;
        end else begin
            ext_clk_sync <= {ext_clk_sync[1:0], ext_bit_clk};
            ext_ref_sync <= {ext_ref_sync[1:0], ext_ref_clk};
            if (div_wrap) div_cnt_reg <= 16'h0000;
            else if (div_step) div_cnt_reg <= div_cnt_reg + 16'h0001;
            if (ext_ref_rise) ref_gap_reg <= 8'h00;
            else if (!ref_lost) ref_gap_reg <= ref_gap_reg + 8'h01;
            tick_hist <= {tick_hist[DLY_MAX-2:0], bit_tick};
        end
    end

    // transmit pattern sources
    logic [22:0]    tx_state;
    logic [7:0]     dens_cnt_reg;
    logic [CIW-1:0] cust_idx_reg;
    wire [7:0]  mark_len  = dens_reg[`PGC_DENS_MARK_LSB +: 8];
    wire [7:0]  space_len = dens_reg[`PGC_DENS_SPACE_LSB +: 8];
    wire [8:0]  dens_per  = {1'b0, mark_len} + {1'b0, space_len};
    wire        dens_last = ({1'b0, dens_cnt_reg} + 9'h001 >= dens_per);
    wire [4:0]  tx_n      = seq_n(ctrl_reg.tx_len);
    wire        prbs_bit  = tx_state[tx_n - 5'd1];
    wire        dens_bit  = (dens_cnt_reg < mark_len);
    wire [31:0] cust_word = cust_reg[cust_idx_reg[CIW-1:5]];
    wire        cust_bit  = cust_word[cust_idx_reg[4:0]];
    logic       src_bit;

    always_comb begin
        case (ctrl_reg.tx_mode)
            pgc_pkg::tx_prbs:    src_bit = prbs_bit;
            pgc_pkg::tx_density: src_bit = dens_bit;
            pgc_pkg::tx_custom:  src_bit = cust_bit;
            default:             src_bit = 1'b0;
        endcase
    end

    wire tx_run = ctrl_reg.tx_en && bit_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state     <= `PGC_SEED;
            dens_cnt_reg <= 8'h00;
            cust_idx_reg <= '0;
            tx_data      <= 1'b0;
            tx_strobe    <= 1'b0;
        end else begin
            tx_strobe <= tx_run;
            if (!ctrl_reg.tx_en) begin
                tx_state     <= `PGC_SEED;
                dens_cnt_reg <= 8'h00;
                cust_idx_reg <= '0;
            end else if (bit_tick) begin
                tx_state     <= seq_shift(tx_state, ctrl_reg.tx_len,
                                          seq_fb(tx_state, ctrl_reg.tx_len));
                dens_cnt_reg <= dens_last ? 8'h00 : dens_cnt_reg + 8'h01;
                cust_idx_reg <= cust_idx_reg + 1'b1;
                tx_data      <= src_bit ^ ctrl_reg.tx_inv;
            end
        end
    end

    // custom memory fill from the fifo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cust_wr_reg <= '0;
            for (int i = 0; i < CUST_WORDS; i++) cust_reg[i] <= 32'h0000_0000;
        end else if (fifo_pop) begin
            cust_reg[cust_wr_reg] <= fifo_out_data;
            cust_wr_reg           <= cust_wr_reg + 1'b1;
        end
    end

    // receive reference and comparison
    pgc_pkg::pgc_rxst_e rx_st_reg;
    pgc_pkg::pgc_rxst_e rx_st_next;
    logic [22:0] rx_state;
    logic [4:0]  load_cnt_reg;
    wire [4:0]   rx_n      = seq_n(ctrl_reg.rx_len);
    wire         rx_true   = rx_data ^ ctrl_reg.rx_inv;
    wire         ref_bit   = ctrl_reg.rx_ext_ref ? ref_data : seq_fb(rx_state, ctrl_reg.rx_len);
    wire         bit_err   = rx_data ^ (ref_bit ^ ctrl_reg.rx_inv);
    wire         locked    = (rx_st_reg == pgc_pkg::rx_locked);
    wire         count_now = locked && samp_tick;
    wire         load_done = (load_cnt_reg == rx_n - 5'd1);

    always_comb begin
        case (rx_st_reg)
            pgc_pkg::rx_off:
                rx_st_next = !ctrl_reg.rx_en ? pgc_pkg::rx_off :
                             ctrl_reg.rx_ext_ref ? pgc_pkg::rx_locked : pgc_pkg::rx_load;
            pgc_pkg::rx_load:
                rx_st_next = (samp_tick && load_done) ? pgc_pkg::rx_locked : pgc_pkg::rx_load;
            pgc_pkg::rx_locked:
                rx_st_next = pgc_pkg::rx_locked;
            default:
                rx_st_next = pgc_pkg::rx_off;
        endcase
        if (!ctrl_reg.rx_en) rx_st_next = pgc_pkg::rx_off;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_reg    <= pgc_pkg::rx_off;
            rx_state     <= `PGC_SEED;
            load_cnt_reg <= 5'd0;
        end else begin
            rx_st_reg <= rx_st_next;
            if (rx_st_reg == pgc_pkg::rx_off) begin
                load_cnt_reg <= 5'd0;
            end else if (samp_tick && rx_st_reg == pgc_pkg::rx_load) begin
                rx_state     <= seq_shift(rx_state, ctrl_reg.rx_len, rx_true);
                load_cnt_reg <= load_cnt_reg + 5'd1;
            end else if (count_now) begin
                rx_state <= seq_shift(rx_state, ctrl_reg.rx_len, ref_bit);
            end
        end
    end

    // counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_reg  <= 32'h0000_0000;
            bits_reg <= 32'h0000_0000;
        end else if (cnt_clr) begin
            err_reg  <= 32'h0000_0000;
            bits_reg <= 32'h0000_0000;
        end else if (count_now) begin
            if (bits_reg != 32'hffff_ffff) bits_reg <= bits_reg + 32'h1;
            if (bit_err && err_reg != 32'hffff_ffff) err_reg <= err_reg + 32'h1;
        end
    end

    // register writes and read capture
    logic [31:0] rd_mux;
    wire [31:0] stat_word = {29'h0, ref_lost, rx_st_reg == pgc_pkg::rx_load, locked};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (a_ctrl) rd_mux = {17'h0, ctrl_reg};
        if (a_dens) rd_mux = {16'h0, dens_reg};
        if (a_div) rd_mux = {16'h0, div_reg};
        if (a_errs) rd_mux = err_reg;
        if (a_bits) rd_mux = bits_reg;
        if (a_stat) rd_mux = stat_word;
        if (a_delay) rd_mux = {{(32 - DW){1'b0}}, delay_reg};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= pgc_pkg::pgc_ctrl_s'(`PGC_CTRL_RST);
            dens_reg    <= `PGC_DENS_RST;
            div_reg     <= `PGC_DIV_RST;
            delay_reg   <= DW'(`PGC_DELAY_RST);
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            if (setup) begin
                prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_reg <= !a_hit;
            end
            if (wr_done && a_ctrl) ctrl_reg <= pgc_pkg::pgc_ctrl_s'(pwdata[`PGC_CTRL_W-1:0]);
            if (wr_done && a_dens) dens_reg <= pwdata[15:0];
            if (wr_done && a_div) div_reg <= pwdata[15:0];
            if (wr_done && a_delay) delay_reg <= pwdata[DW-1:0];
        end
    end
endmodule

/* File: core/pgc_defines.svh */
// register offsets, field positions, reset values and timing counts of the test pattern block
// included by the package users; definitions only
`ifndef PGC_DEFINES_SVH
`define PGC_DEFINES_SVH

`define PGC_OFF_CTRL      8'h00
`define PGC_OFF_DENS      8'h04
`define PGC_OFF_CUST      8'h08
`define PGC_OFF_DIV       8'h0c
`define PGC_OFF_ERRS      8'h10
`define PGC_OFF_BITS      8'h14
`define PGC_OFF_STAT      8'h18
`define PGC_OFF_CLR       8'h1c
`define PGC_OFF_DELAY     8'h20

`define PGC_CTRL_W        15
`define PGC_CTRL_RST      15'h0000
`define PGC_DENS_RST      16'h0101
`define PGC_DIV_RST       16'h0000
`define PGC_DELAY_RST     4'h0
`define PGC_SEED          23'h000001

`define PGC_DENS_MARK_LSB 0
`define PGC_DENS_SPACE_LSB 8
`define PGC_STAT_LOCK_BIT 0
`define PGC_STAT_LOAD_BIT 1
`define PGC_STAT_REFL_BIT 2

`define PGC_PCLK_MHZ      100
`define PGC_REF_MHZ       10
`define PGC_REF_CYC       (`PGC_PCLK_MHZ / `PGC_REF_MHZ)
`define PGC_REF_LOST_CYC  (4 * `PGC_REF_CYC)

`endif

/* File: core/pgc_pkg.sv */
// types shared by the test pattern block
// no imports; users write pgc_pkg::name
package pgc_pkg;

    typedef enum logic [2:0] {
        seq_len_seven       = 3'h0,
        seq_len_fifteen     = 3'h1,
        seq_len_seventeen   = 3'h2,
        seq_len_twenty      = 3'h3,
        seq_len_twentythree = 3'h4,
        seq_len_test_four   = 3'h5
    } pgc_len_e;

    typedef enum logic [1:0] {
        tx_prbs    = 2'h0,
        tx_density = 2'h1,
        tx_custom  = 2'h2,
        tx_idle    = 2'h3
    } pgc_txmode_e;

    typedef enum logic [2:0] {
        rx_off    = 3'b001,
        rx_load   = 3'b010,
        rx_locked = 3'b100
    } pgc_rxst_e;

    typedef struct packed {
        logic        rx_en;
        logic        ref_clk_sel;
        logic        ext_clk_sel;
        logic        rx_ext_ref;
        logic        rx_inv;
        pgc_len_e    rx_len;
        pgc_txmode_e tx_mode;
        logic        tx_inv;
        pgc_len_e    tx_len;
        logic        tx_en;
    } pgc_ctrl_s;

endpackage

/* File: core/pgc_fifo.sv */
// synchronous fifo, flip-flop storage, valid/ready on both sides
// single clock, async active-low reset
`timescale 1ns/1ps
module pgc_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    wire [AW-1:0]  wr_inc = (wr_reg == AW'(D - 1)) ? '0 : wr_reg + 1'b1;
    wire [AW-1:0]  rd_inc = (rd_reg == AW'(D - 1)) ? '0 : rd_reg + 1'b1;

    assign in_ready  = (cnt_reg != (AW + 1)'(D));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_inc;
            if (pop) rd_reg <= rd_inc;
            if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge pclk) begin
        if (push) mem_reg[wr_reg] <= in_data;
    end
endmodule

/* File: bench/pgc_chk.sv */
// port checker for the pattern block: apb answers and transmit bit timing
// bound to pgc_bert; single pclk domain
`timescale 1ns/1ps
module pgc_chk (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // transmit link
    input wire logic        tx_data,
    input wire logic        tx_strobe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    a_unmapped_err: assert property (s_setup ##1 (psel && penable && paddr > 8'h20) |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (s_setup ##1 (psel && penable && paddr <= 8'h20
        && paddr[1:0] == 2'h0) |-> !pslverr)
        else $error("error on mapped register");
    a_refused_zero: assert property (s_setup ##1 (psel && penable && !pwrite
        && (pslverr || paddr == 8'h08 || paddr == 8'h1c)) |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_ready_cust_only: assert property (!pready |-> psel && penable && pwrite && paddr == 8'h08)
        else $error("wait state outside custom write");
    a_zero_wait: assert property (s_setup ##1 (psel && penable && !(pwrite
        && paddr == 8'h08)) |-> pready)
        else $error("access not answered at once");
    a_read_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
        else $error("read data moved outside setup");
    a_tx_on_strobe: assert property ($changed(tx_data) |-> tx_strobe)
        else $error("transmit bit changed without strobe");
endmodule

bind pgc_bert pgc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tx_data(tx_data), .tx_strobe(tx_strobe));

/* File: bench/pgc_far_model.sv */
// far-side model: returns each transmit bit, corrupts one bit on request
// assumes tx_strobe marks every new tx_data bit
`timescale 1ns/1ps
module pgc_far_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // from the block
    input  wire logic tx_data,
    input  wire logic tx_strobe,
    // bench control
    input  wire logic inj,
    // back to the block
    output logic      rx_data,
    output logic      ref_data
);
    // returned bit and reference change together, one cycle after the strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data  <= 1'b0;
            ref_data <= 1'b0;
        end else if (tx_strobe) begin
            rx_data  <= tx_data ^ inj;
            ref_data <= tx_data;
        end
    end
endmodule

/* File: bench/tb.sv */
// self-checking bench: registers, transmit patterns, loopback error counts
// assumes pgc_far_model at the link and pgc_chk bound to the block
`timescale 1ns/1ps
module tb;
    localparam int TBL[7][6] = '{'{5, 4, 3, 4, 0, 1}, '{0, 7, 6, 7, 0, 0},
        '{0, 7, 6, 7, 1, 0}, '{1, 15, 14, 15, 0, 0}, '{2, 17, 14, 17, 0, 0},
        '{3, 20, 17, 20, 0, 0}, '{4, 23, 18, 23, 1, 0}};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        ext_bit_clk = 1'b0;
    logic        ext_ref_clk = 1'b0;
    logic        inj = 1'b0;
    logic        pready, pslverr, tx_data, tx_strobe, rx_data, ref_data;
    logic [31:0] prdata;
    logic [32:0] rq[$];
    logic        tq[$];
    logic [31:0] rnd = 32'd93;
    logic [31:0] cw[4];
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n_inj;
    pgc_pkg::pgc_ctrl_s c;

    always #5 pclk = ~pclk;
    always #50 ext_ref_clk = ~ext_ref_clk;

    pgc_bert u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ext_bit_clk(ext_bit_clk), .ext_ref_clk(ext_ref_clk),
        .tx_data(tx_data), .tx_strobe(tx_strobe), .rx_data(rx_data), .ref_data(ref_data));
    pgc_far_model u_far (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
        .tx_strobe(tx_strobe), .inj(inj), .rx_data(rx_data), .ref_data(ref_data));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watcher: takes the oldest note whenever a result shows
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready && !pwrite && rq.size() > 0) begin
            check("apb read", {pslverr, prdata}, rq.pop_front());
        end
        if (tx_strobe && tq.size() > 0) begin
            check("tx bit", {32'h0, tx_data}, {32'h0, tq.pop_front()});
        end
        if (cyc > 60000) begin
            n_fail++;
            results();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rq.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wctrl();
        apb(1'b1, 8'h00, {17'h0, c});
    endtask
    task automatic run_tx();
        wctrl();
        while (tq.size() > 0) @(posedge pclk);
        c = '0;
        wctrl();
        repeat (4) @(posedge pclk);
    endtask
    task automatic edges(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_bit_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_bit_clk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask
    task automatic push_prbs(input int n, input int ta, input int tb, input logic inv);
        logic [23:0] s;
        logic        fb;
        s = 24'h000002;
        repeat (200) begin
            tq.push_back(s[n] ^ inv);
            fb = s[ta] ^ s[tb];
            s = {s[22:0], 1'b0};
            s[1] = fb;
        end
    endtask

    initial begin
        c = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, refused places, read-back
        rd(8'h00, 33'h0);
        rd(8'h04, 33'h0_0000_0101);
        rd(8'h0c, 33'h0);
        rd(8'h20, 33'h0);
        rd(8'h08, 33'h0);
        rd(8'h40, 33'h1_0000_0000);
        rnd = xs(rnd);
        apb(1'b1, 8'h20, {29'h0, rnd[2:0]});
        rd(8'h20, {30'h0, rnd[2:0]});
        apb(1'b1, 8'h0c, {30'h0, rnd[5:4]});
        // every sequence length, one random divider, reference tick on the test-four length only
        for (int k = 0; k < 7; k++) begin
            push_prbs(TBL[k][1], TBL[k][2], TBL[k][3], TBL[k][4][0]);
            c.tx_len = pgc_pkg::pgc_len_e'(TBL[k][0][2:0]);
            c.tx_inv = TBL[k][4][0];
            c.ref_clk_sel = TBL[k][5][0];
            c.tx_en = 1'b1;
            run_tx();
        end
        // custom memory pattern through the fifo
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            cw[i] = rnd;
            apb(1'b1, 8'h08, rnd);
        end
        repeat (10) @(posedge pclk);
        for (int i = 0; i < 160; i++) tq.push_back(cw[(i / 32) % 4][i % 32]);
        c.tx_mode = pgc_pkg::tx_custom;
        c.tx_en = 1'b1;
        run_tx();
        // mark/space density with random group lengths 1..8
        rnd = xs(rnd);
        apb(1'b1, 8'h04, {21'h0, rnd[10:8], 5'h0, rnd[2:0]} + 32'h0000_0101);
        for (int i = 0; i < 60; i++)
            tq.push_back((i % (int'(rnd[2:0]) + int'(rnd[10:8]) + 2)) < (int'(rnd[2:0]) + 1));
        c.tx_mode = pgc_pkg::tx_density;
        c.tx_en = 1'b1;
        run_tx();
        // loopback on external clock: own reference, then external reference
        for (int m = 0; m < 2; m++) begin
            c = '0;
            c.tx_en = 1'b1;
            c.ext_clk_sel = 1'b1;
            c.rx_en = 1'b1;
            c.tx_inv = (m == 0);
            c.rx_inv = (m == 0);
            c.rx_ext_ref = (m == 1);
            wctrl();
            edges(20);
            rd(8'h18, 33'h1);
            apb(1'b1, 8'h1c, 32'h0);
            n_inj = 0;
            for (int i = 0; i < 40; i++) begin
                rnd = xs(rnd);
                inj <= rnd[0] && i < 39;
                n_inj += int'(rnd[0] && i < 39);
                edges(1);
            end
            repeat (20) @(posedge pclk);
            rd(8'h10, {1'b0, 32'(n_inj)});
            rd(8'h14, 33'd40);
            c = '0;
            wctrl();
        end
        repeat (4) @(posedge pclk);
        results();
    end
endmodule
